// ### hdl/tcrb_pkg.sv
package tcrb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map on the serial link
    localparam int unsigned CTRL_NUM = 6;
    localparam logic [4:0] REG_MODE_IRQ = 5'h00;
    localparam logic [4:0] REG_TRIM_LOW = 5'h01;
    localparam logic [4:0] REG_TRIM_HIGH = 5'h02;
    localparam logic [4:0] REG_MOD_SLEEP = 5'h03;
    localparam logic [4:0] REG_BITCHK_LIMMIN = 5'h04;
    localparam logic [4:0] REG_BAUD_LIMMAX = 5'h05;
    localparam logic [4:0] ADDR_STATUS = 5'h08;
    localparam logic [4:0] ADDR_BUFFER = 5'h10;
    localparam int unsigned CMD_READ_BIT = 7;

    // Reset values and writable bits, indexed by register number
    localparam logic [7:0] CTRL_RESET [CTRL_NUM] = '{8'h80, 8'hB0, 8'h0B, 8'h28, 8'h50, 8'h9C};
    localparam logic [7:0] CTRL_WMASK [CTRL_NUM] = '{8'hF7, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF};
    localparam logic [7:0] OUT_FORCE_MASK = 8'h03;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned IRQ_LVL_LSB = 6;
    localparam int unsigned AN_SUP_BIT = 5;
    localparam int unsigned BAND_BIT = 4;
    localparam int unsigned OPM_LSB = 1;
    localparam int unsigned TMODE_BIT = 0;
    localparam int unsigned TRIM_LOW_LSB = 1;
    localparam int unsigned CODING_BIT = 0;
    localparam int unsigned TRIM_HIGH_LSB = 2;
    localparam int unsigned SUP_OUT_BIT = 1;
    localparam int unsigned CLK_OUT_BIT = 0;
    localparam int unsigned MOD_BIT = 7;
    localparam int unsigned SLEEP_LSB = 2;
    localparam int unsigned SLEEP_MULTIPLIER_SELECT_BIT = 1;
    localparam int unsigned LIMIT_MULTIPLIER_SELECT_BIT = 0;
    localparam int unsigned ST_PWR_BIT = 7;
    localparam int unsigned ST_AUX_BIT = 6;
    localparam int unsigned ST_LOWBAT_BIT = 5;

    typedef enum logic [1:0] {
        OPM_IDLE = 2'h0,
        OPM_TX = 2'h1,
        OPM_RX_POLL = 2'h2,
        OPM_RX = 2'h3
    } tcrb_opmode_e;

    ////////////////////////////////////////////////////////////////////////////
    // Buffer, interrupt levels, timing scale
    localparam int unsigned BUF_DEPTH = 16;
    localparam int unsigned BUF_AW = 4;
    localparam logic [1:0] IRQ_LVL_ERR_ONLY = 2'h3;
    localparam logic [4:0] IRQ_THR_4 = 5'h04;
    localparam logic [4:0] IRQ_THR_8 = 5'h08;
    localparam logic [4:0] IRQ_THR_12 = 5'h0C;
    localparam int unsigned SLEEP_UNIT_LOG2 = 10;
    localparam int unsigned SLEEP_MULTIPLIER_SELECT_LOG2 = 3;
    localparam logic [1:0] LIMIT_MULTIPLIER_SELECT_ONE = 2'h1;
    localparam logic [1:0] LIMIT_MULTIPLIER_SELECT_TWO = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Serial frame and synchroniser layout
    localparam logic [4:0] SPI_CMD_LAST = 5'h07;
    localparam logic [4:0] SPI_DATA_FIRST = 5'h08;
    localparam logic [4:0] SPI_DATA_LAST = 5'h0F;
    localparam logic [4:0] SPI_FRAME_BITS = 5'h10;
    localparam int unsigned SYNC_W = 11;
    localparam logic [SYNC_W-1:0] SYNC_PREV_RESET = 11'h000;

endpackage

// ### hdl/tcrb_sync.sv
`timescale 1ns/100ps
module tcrb_sync #(
    parameter int unsigned W = 1
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_ff;

    // Two-stage synchroniser; the first stage feeds only the second
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_ff <= '0;
            q_out <= '0;
        end else begin
            meta_ff <= d_in;
            q_out <= meta_ff;
        end
    end
endmodule // tcrb_sync

// ### hdl/tcrb_buf_ram.sv
`timescale 1ns/100ps
module tcrb_buf_ram
    import tcrb_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic wr_en_in,
    input wire logic [tcrb_pkg::BUF_AW-1:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic rd_en_in,
    input wire logic [tcrb_pkg::BUF_AW-1:0] rd_addr_in,
    output logic [7:0] rd_data_out
);
    logic [7:0] mem [BUF_DEPTH];

    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    // Registered read port
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_data_out <= 8'h00;
        end else if (rd_en_in) begin
            rd_data_out <= mem[rd_addr_in];
        end
    end
endmodule // tcrb_buf_ram

// ### hdl/tcrb_reg_bank.sv
// Operation
// - Sixteen-byte buffer plus six control registers
// - Status byte readable, never writable
// - Contents kept while powered, lost at off
// - Every turn-on loads control register defaults
// - Receive interrupt at 4/8/12 bytes or error
// - Transmit interrupt at 4/8/12 left or empty
// - Analog supply bit enables supply in aux
// - Band select bit picks frequency band
// - Two bits choose idle, transmit, poll, receive
// - Transparent bit bypasses buffer through serial pins
// - Low seven trim bits, default 88
// - Two high trim bits add 0..384
// - Bit-check interrupt unless coding bit set
// - Coding bit picks Manchester or NRZ transmit
// - Supply output enable bit, default on
// - Bit-check, button, power-on force outputs on
// - Clock output enable bit, default on
// - Modulation bit picks FSK or ASK
// - Sleep count scales sleep period by 1024
// - Sleep multiplier bit gives one or eight
// - Limit multiplier bit gives one or two
// - Status read clears flags and interrupt
`timescale 1ns/100ps
module tcrb_reg_bank
    import tcrb_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic serial_in_pin_in,
    output logic serial_out_pin_out,
    input wire logic power_on_input_in,
    input wire logic auxiliary_supply_input_in,
    input wire logic low_batt_in,
    input wire logic [4:0] push_button_n_in,
    input wire logic rx_byte_valid_in,
    input wire logic [7:0] rx_byte_in,
    input wire logic rx_error_in,
    input wire logic bitcheck_ok_in,
    input wire logic tx_byte_req_in,
    output logic [7:0] tx_byte_out,
    output logic tx_byte_valid_out,
    input wire logic rx_stream_in,
    output logic tx_stream_out,
    output logic irq_out,
    output logic analog_supply_enable_out,
    output logic band_select_out,
    output tcrb_pkg::tcrb_opmode_e op_mode_out,
    output logic transparent_mode_out,
    output logic [8:0] trim_value_out,
    output logic manchester_enable_out,
    output logic supply_output_enable_out,
    output logic clk_out_enable_out,
    output logic modulation_select_out,
    output logic [17:0] sleep_period_out,
    output logic [1:0] limit_multiplier_out,
    output logic [4:0] buffer_count_out
);
    import tcrb_pkg::*;

    function automatic logic is_ctrl_addr(input logic [4:0] addr);
        is_ctrl_addr = (addr < 5'(CTRL_NUM));
    endfunction

    function automatic logic [4:0] irq_threshold(input logic [1:0] lvl);
        unique case (lvl)
            2'h0: irq_threshold = IRQ_THR_4;
            2'h1: irq_threshold = IRQ_THR_8;
            2'h2: irq_threshold = IRQ_THR_12;
            default: irq_threshold = 5'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: frame is an 8-bit command then an 8-bit data byte
    logic [4:0] bit_cnt_ff;
    logic [7:0] in_sh_ff;
    logic [7:0] cmd_ff;
    logic [7:0] wdata_ff;
    logic cmd_tgl_ff;
    logic wr_tgl_ff;
    logic [7:0] out_sh_ff;
    logic [7:0] rd_data_ff;
    wire logic [7:0] spi_byte = {in_sh_ff[6:0], serial_in_pin_in};
    wire logic cmd_done = (bit_cnt_ff == SPI_CMD_LAST);
    wire logic wr_done = (bit_cnt_ff == SPI_DATA_LAST) && !cmd_ff[CMD_READ_BIT];

    always_ff @(posedge sck_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            bit_cnt_ff <= 5'h00;
            in_sh_ff <= 8'h00;
        end else begin
            if (bit_cnt_ff != SPI_FRAME_BITS) begin
                bit_cnt_ff <= bit_cnt_ff + 5'h01;
            end
            in_sh_ff <= spi_byte;
        end
    end

    // Command and write data stay put until the next frame; toggles flag them
    always_ff @(posedge sck_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cmd_ff <= 8'h00;
            wdata_ff <= 8'h00;
            cmd_tgl_ff <= 1'b0;
            wr_tgl_ff <= 1'b0;
        end else begin
            if (cmd_done) begin
                cmd_ff <= spi_byte;
                cmd_tgl_ff <= !cmd_tgl_ff;
            end
            if (wr_done) begin
                wdata_ff <= spi_byte;
                wr_tgl_ff <= !wr_tgl_ff;
            end
        end
    end

    // Read data is held stable by the system side before the host clocks it out
    always_ff @(negedge sck_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            out_sh_ff <= 8'h00;
        end else if (bit_cnt_ff == SPI_DATA_FIRST) begin
            out_sh_ff <= rd_data_ff;
        end else begin
            out_sh_ff <= {out_sh_ff[6:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Crossing into the system domain
    logic [SYNC_W-1:0] sync_q;
    logic [SYNC_W-1:0] sync_prev_ff;

    tcrb_sync #(.W(SYNC_W)) u_sync (
        .clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .d_in({cmd_tgl_ff, wr_tgl_ff, serial_in_pin_in, power_on_input_in,
               auxiliary_supply_input_in, low_batt_in, push_button_n_in}),
        .q_out(sync_q)
    );

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync_prev_ff <= SYNC_PREV_RESET;
        end else begin
            sync_prev_ff <= sync_q;
        end
    end

    wire logic cmd_evt = sync_q[10] ^ sync_prev_ff[10];
    wire logic wr_evt = sync_q[9] ^ sync_prev_ff[9];
    wire logic serial_in_s = sync_q[8];
    wire logic pwr_rise = sync_q[7] && !sync_prev_ff[7];
    wire logic aux_rise = sync_q[6] && !sync_prev_ff[6];
    wire logic aux_s = sync_q[6];
    wire logic low_batt_s = sync_q[5];
    wire logic [4:0] btn_n_s = sync_q[4:0];
    wire logic push_evt = |(~btn_n_s & sync_prev_ff[4:0]);

    ////////////////////////////////////////////////////////////////////////////
    // Host command decode
    wire logic [4:0] cmd_addr = cmd_ff[4:0];
    wire logic host_rd = cmd_evt && cmd_ff[CMD_READ_BIT];
    wire logic host_wr = wr_evt;
    wire logic addr_is_ctrl = is_ctrl_addr(cmd_addr);
    wire logic addr_is_status = (cmd_addr == ADDR_STATUS);
    wire logic addr_is_buf = (cmd_addr == ADDR_BUFFER);

    ////////////////////////////////////////////////////////////////////////////
    // Control registers
    logic [7:0] ctrl_ff [CTRL_NUM];
    logic [7:0] nxt_ctrl [CTRL_NUM];
    logic pwr_flag_ff;
    wire logic [1:0] irq_lvl = ctrl_ff[0][IRQ_LVL_LSB +: 2];
    wire logic [1:0] opm = ctrl_ff[0][OPM_LSB +: 2];
    wire logic transparent = ctrl_ff[0][TMODE_BIT];
    wire logic p_mode = ctrl_ff[1][CODING_BIT];
    wire logic tx_mode = (opm == OPM_TX);
    wire logic rx_mode = opm[1];
    wire logic force_out_on = (bitcheck_ok_in && rx_mode) || push_evt || pwr_flag_ff;

    for (genvar i = 0; i < CTRL_NUM; i++) begin : g_ctrl
        wire logic hit = host_wr && addr_is_ctrl && (cmd_addr == 5'(i));
        wire logic [7:0] written = hit ? (wdata_ff & CTRL_WMASK[i]) : ctrl_ff[i];
        wire logic force_here = force_out_on && (5'(i) == REG_TRIM_HIGH);
        // Hardware force beats a simultaneous host write
        assign nxt_ctrl[i] = force_here ? (written | OUT_FORCE_MASK) : written;

        always_ff @(posedge sys_clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
                ctrl_ff[i] <= CTRL_RESET[i];
            end else begin
                ctrl_ff[i] <= nxt_ctrl[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data buffer, run as a FIFO
    logic [BUF_AW-1:0] wr_ptr_ff;
    logic [BUF_AW-1:0] rd_ptr_ff;
    logic [4:0] count_ff;
    logic [7:0] mem_q;
    wire logic buf_full = (count_ff == SPI_FRAME_BITS);
    wire logic buf_empty = (count_ff == 5'h00);
    wire logic host_push = host_wr && addr_is_buf && !rx_mode && !buf_full && !transparent;
    wire logic core_push = rx_byte_valid_in && rx_mode && !buf_full && !transparent;
    wire logic host_pop = host_rd && addr_is_buf && !tx_mode && !buf_empty;
    wire logic core_pop = tx_byte_req_in && tx_mode && !buf_empty && !transparent;
    wire logic push = host_push || core_push;
    wire logic pop = host_pop || core_pop;
    wire logic [7:0] push_data = core_push ? rx_byte_in : wdata_ff;
    wire logic [4:0] nxt_count = count_ff + {4'h0, push} - {4'h0, pop};

    tcrb_buf_ram u_buf_ram (
        .clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .wr_en_in(push),
        .wr_addr_in(wr_ptr_ff),
        .wr_data_in(push_data),
        .rd_en_in(pop),
        .rd_addr_in(rd_ptr_ff),
        .rd_data_out(mem_q)
    );

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= 5'h00;
        end else begin
            wr_ptr_ff <= wr_ptr_ff + BUF_AW'(push);
            rd_ptr_ff <= rd_ptr_ff + BUF_AW'(pop);
            count_ff <= nxt_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags and host read path
    logic aux_flag_ff;
    logic low_flag_ff;
    logic irq_ff;
    logic host_buf_pend_ff;
    logic host_buf_ok_ff;
    logic tx_valid_ff;
    wire logic status_clr = host_rd && addr_is_status;
    wire logic [7:0] status_val = {pwr_flag_ff, aux_flag_ff, low_flag_ff, ~btn_n_s};
    wire logic [7:0] ctrl_rd = addr_is_ctrl ? ctrl_ff[cmd_addr[2:0]] : 8'h00;
    wire logic [7:0] host_rd_val = addr_is_ctrl ? ctrl_rd : (addr_is_status ? status_val : 8'h00);
    wire logic [7:0] nxt_rd_data = host_buf_pend_ff ? (host_buf_ok_ff ? mem_q : 8'h00) :
                                   (host_rd && !addr_is_buf) ? host_rd_val : rd_data_ff;

    // Set wins over a status-read clear
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pwr_flag_ff <= 1'b0;
            aux_flag_ff <= 1'b0;
            low_flag_ff <= 1'b0;
        end else begin
            pwr_flag_ff <= pwr_rise || (pwr_flag_ff && !status_clr);
            aux_flag_ff <= aux_rise || (aux_flag_ff && !status_clr);
            low_flag_ff <= low_batt_s || (low_flag_ff && !status_clr);
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            host_buf_pend_ff <= 1'b0;
            host_buf_ok_ff <= 1'b0;
            tx_valid_ff <= 1'b0;
            rd_data_ff <= 8'h00;
        end else begin
            host_buf_pend_ff <= host_rd && addr_is_buf;
            host_buf_ok_ff <= host_pop;
            tx_valid_ff <= core_pop;
            rd_data_ff <= nxt_rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt sources
    wire logic [4:0] thr = irq_threshold(irq_lvl);
    wire logic lvl_used = (irq_lvl != IRQ_LVL_ERR_ONLY);
    wire logic rx_lvl_hit = core_push && lvl_used && (nxt_count == thr);
    wire logic rx_irq = rx_mode && (rx_lvl_hit || rx_error_in);
    wire logic tx_left_hit = lvl_used && (nxt_count == thr);
    wire logic tx_irq = core_pop && (tx_left_hit || nxt_count == 5'h00);
    wire logic bc_irq = bitcheck_ok_in && rx_mode && !p_mode;
    wire logic irq_set = rx_irq || tx_irq || bc_irq || pwr_rise || aux_rise || push_evt;

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= irq_set || (irq_ff && !status_clr);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration outputs
    logic an_sup_ff;
    logic [8:0] trim_ff;
    logic [17:0] sleep_ff;
    logic [1:0] limit_multiplier_select_ff;
    logic tx_stream_ff;
    logic rx_stream_ff;
    wire logic [4:0] sleep_cnt = ctrl_ff[3][SLEEP_LSB +: 5];
    wire logic [17:0] sleep_base = {3'h0, sleep_cnt, 10'h000};
    wire logic [17:0] nxt_sleep = ctrl_ff[3][SLEEP_MULTIPLIER_SELECT_BIT] ? (sleep_base << SLEEP_MULTIPLIER_SELECT_LOG2) : sleep_base;

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            an_sup_ff <= 1'b0;
            trim_ff <= 9'h000;
            sleep_ff <= 18'h00000;
            limit_multiplier_select_ff <= LIMIT_MULTIPLIER_SELECT_ONE;
            tx_stream_ff <= 1'b0;
            rx_stream_ff <= 1'b0;
        end else begin
            an_sup_ff <= !aux_s || ctrl_ff[0][AN_SUP_BIT];
            trim_ff <= {ctrl_ff[2][TRIM_HIGH_LSB +: 2], ctrl_ff[1][TRIM_LOW_LSB +: 7]};
            sleep_ff <= nxt_sleep;
            limit_multiplier_select_ff <= ctrl_ff[3][LIMIT_MULTIPLIER_SELECT_BIT] ? LIMIT_MULTIPLIER_SELECT_TWO : LIMIT_MULTIPLIER_SELECT_ONE;
            tx_stream_ff <= transparent && serial_in_s;
            rx_stream_ff <= rx_stream_in;
        end
    end

    assign serial_out_pin_out = transparent ? rx_stream_ff : out_sh_ff[7];
    assign tx_stream_out = tx_stream_ff;
    assign tx_byte_out = mem_q;
    assign tx_byte_valid_out = tx_valid_ff;
    assign irq_out = irq_ff;
    assign analog_supply_enable_out = an_sup_ff;
    assign band_select_out = ctrl_ff[0][BAND_BIT];
    assign op_mode_out = tcrb_opmode_e'(opm);
    assign transparent_mode_out = transparent;
    assign trim_value_out = trim_ff;
    assign manchester_enable_out = !p_mode;
    assign supply_output_enable_out = ctrl_ff[2][SUP_OUT_BIT];
    assign clk_out_enable_out = ctrl_ff[2][CLK_OUT_BIT];
    assign modulation_select_out = ctrl_ff[3][MOD_BIT];
    assign sleep_period_out = sleep_ff;
    assign limit_multiplier_out = limit_multiplier_select_ff;
    assign buffer_count_out = count_ff;

endmodule // tcrb_reg_bank

// ### verif/tcrb_reg_bank_asserts.sv
`timescale 1ns/100ps
module tcrb_reg_bank_asserts
    import tcrb_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire tcrb_pkg::tcrb_opmode_e op_mode_out,
    input wire logic rx_error_in,
    input wire logic bitcheck_ok_in,
    input wire logic rx_byte_valid_in,
    input wire logic tx_byte_req_in,
    input wire logic tx_byte_valid_out,
    input wire logic irq_out,
    input wire logic manchester_enable_out,
    input wire logic supply_output_enable_out,
    input wire logic clk_out_enable_out,
    input wire logic transparent_mode_out,
    input wire logic tx_stream_out,
    input wire logic [4:0] buffer_count_out,
    input wire logic [17:0] sleep_period_out,
    input wire logic [1:0] limit_multiplier_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    wire logic rx_mode = op_mode_out[1];
    wire logic tx_pop = op_mode_out == OPM_TX && !transparent_mode_out && tx_byte_req_in;

    a_rx_err_irq: assert property (rx_mode && rx_error_in |=> irq_out) else $error("no irq on error");
    a_chk_irq: assert property (rx_mode && bitcheck_ok_in && manchester_enable_out |=> irq_out)
        else $error("no irq on bit-check");
    a_chk_force: assert property (rx_mode && bitcheck_ok_in |=> ##[0:2] (supply_output_enable_out && clk_out_enable_out))
        else $error("no force");
    a_pop_valid: assert property (tx_pop && buffer_count_out != 5'h00 |=> tx_byte_valid_out)
        else $error("pop gave no byte");
    a_valid_cause: assert property (tx_byte_valid_out |-> $past(tx_byte_req_in)) else $error("unrequested byte");
    a_count_max: assert property (buffer_count_out <= 5'h10) else $error("count above depth");
    a_push_count: assert property (rx_mode && !transparent_mode_out && rx_byte_valid_in && buffer_count_out < 5'h10
        |=> buffer_count_out == $past(buffer_count_out) + 5'h01) else $error("push not counted");
    a_stream_off: assert property (!transparent_mode_out && !$past(transparent_mode_out) |-> !tx_stream_out)
        else $error("stray stream");
    a_empty_irq: assert property (op_mode_out == OPM_TX && tx_byte_valid_out && buffer_count_out == 5'h00
        |-> ##[0:1] irq_out) else $error("no irq on empty");
    a_limit_val: assert property (limit_multiplier_out inside {2'h1, 2'h2}) else $error("bad limit factor");
    a_sleep_max: assert property (sleep_period_out <= 18'h3E000) else $error("sleep too long");

    c_rx_push: cover property (rx_mode && rx_byte_valid_in);
    c_tx_pop: cover property (tx_byte_valid_out);
    c_bitchk: cover property (rx_mode && bitcheck_ok_in);
endmodule // tcrb_reg_bank_asserts

bind tcrb_reg_bank tcrb_reg_bank_asserts chk_u (.sys_clk_in, .nrst_in, .op_mode_out, .rx_error_in, .bitcheck_ok_in,
    .rx_byte_valid_in, .tx_byte_req_in, .tx_byte_valid_out, .irq_out, .manchester_enable_out, .supply_output_enable_out,
    .clk_out_enable_out, .transparent_mode_out, .tx_stream_out, .buffer_count_out, .sleep_period_out,
    .limit_multiplier_out);

// ### verif/tcrb_host_model.sv
`timescale 1ns/100ps
module tcrb_host_model (
    output logic sck_out,
    output logic cs_n_out,
    output logic sdi_out,
    input wire logic sdo_in
);
    initial {sck_out, cs_n_out, sdi_out} = 3'b010;
    // 16-bit frame, MSB first; clock idles low
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
        logic [15:0] sh;
        sh = {cmd, wd};
        #1.3 cs_n_out = 1'b0;
        for (int i = 0; i < 16; i++) begin
            sdi_out = sh[15-i];
            #3 sck_out = 1'b1;
            if (i >= 8) rd[15-i] = sdo_in;
            // Pause lets read data cross into the link domain
            if (i == 7) #90;
            #3 sck_out = 1'b0;
        end
        #3 cs_n_out = 1'b1;
        sdi_out = ~sdi_out;
        #90;
    endtask
endmodule // tcrb_host_model

// ### verif/tcrb_reg_bank_test.sv
`timescale 1ns/100ps
module tcrb_reg_bank_test;
    import tcrb_pkg::*;
    logic sys_clk_in, nrst_in, sck_in, cs_n_in, serial_in_pin_in, serial_out_pin_out, power_on_input_in;
    logic auxiliary_supply_input_in, low_batt_in, rx_byte_valid_in, rx_error_in, bitcheck_ok_in, tx_byte_req_in;
    logic tx_byte_valid_out, rx_stream_in, tx_stream_out, irq_out, analog_supply_enable_out, band_select_out;
    logic transparent_mode_out, manchester_enable_out, supply_output_enable_out, clk_out_enable_out;
    logic modulation_select_out;
    logic [4:0] push_button_n_in, buffer_count_out;
    logic [7:0] rx_byte_in, tx_byte_out;
    tcrb_opmode_e op_mode_out;
    logic [8:0] trim_value_out;
    logic [17:0] sleep_period_out;
    logic [1:0] limit_multiplier_out;
    int err_count = 0, cmp_count = 0, cyc = 0;

    tcrb_reg_bank dut_u (.sys_clk_in, .nrst_in, .sck_in, .cs_n_in, .serial_in_pin_in, .serial_out_pin_out,
        .power_on_input_in, .auxiliary_supply_input_in, .low_batt_in, .push_button_n_in, .rx_byte_valid_in,
        .rx_byte_in, .rx_error_in, .bitcheck_ok_in, .tx_byte_req_in, .tx_byte_out, .tx_byte_valid_out, .rx_stream_in,
        .tx_stream_out, .irq_out, .analog_supply_enable_out, .band_select_out, .op_mode_out, .transparent_mode_out,
        .trim_value_out, .manchester_enable_out, .supply_output_enable_out, .clk_out_enable_out,
        .modulation_select_out, .sleep_period_out, .limit_multiplier_out, .buffer_count_out);
    tcrb_host_model host_u (.sck_out(sck_in), .cs_n_out(cs_n_in), .sdi_out(serial_in_pin_in),
        .sdo_in(serial_out_pin_out));

    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic cyc_wait(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] r;
        host_u.xfer({3'h0, a}, d, r);
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] r;
        host_u.xfer({3'h4, a}, 8'h00, r);
        chk({10'h0, r}, {10'h0, e});
    endtask
    task automatic pulse_chk(ref logic s, input logic e);
        cyc_wait(1);
        s = 1'b1;
        cyc_wait(1);
        s = 1'b0;
        cyc_wait(2);
        chk({17'h0, irq_out}, {17'h0, e});
        if (e) rd_chk(ADDR_STATUS, 8'h00);
    endtask

    task automatic t_reset_state();
        chk({17'h0, irq_out}, 18'h1);
        rd_chk(ADDR_STATUS, 8'h80);
        chk({17'h0, irq_out}, 18'h0);
        rd_chk(5'h00, 8'h80);
        rd_chk(5'h01, 8'hB0);
        rd_chk(5'h02, 8'h0B);
        rd_chk(5'h03, 8'h28);
        chk({9'h0, trim_value_out}, 18'h158);
        chk(sleep_period_out, 18'h2800);
        chk({16'h0, limit_multiplier_out}, 18'h1);
        chk({15'h0, manchester_enable_out, supply_output_enable_out, clk_out_enable_out}, 18'h7);
        chk({14'h0, modulation_select_out, band_select_out, op_mode_out}, 18'h0);
    endtask
    task automatic t_fields();
        wr(5'h00, 8'hFE);
        rd_chk(5'h00, 8'hF6);
        for (int m = 0; m < 4; m++) begin
            wr(5'h00, 8'(m * 2));
            chk({16'h0, op_mode_out}, 18'(m));
        end
        wr(5'h00, 8'h11);
        chk({16'h0, band_select_out, transparent_mode_out}, 18'h3);
        rx_stream_in = 1'b1;
        cyc_wait(3);
        chk({17'h0, serial_out_pin_out}, 18'h1);
        rx_stream_in = 1'b0;
        auxiliary_supply_input_in = 1'b1;
        cyc_wait(6);
        chk({16'h0, serial_out_pin_out, analog_supply_enable_out}, 18'h0);
        wr(5'h00, 8'h20);
        rd_chk(ADDR_STATUS, 8'h40);
        chk({17'h0, analog_supply_enable_out}, 18'h1);
        cyc_wait(1);
        auxiliary_supply_input_in = 1'b0;
    endtask
    task automatic t_trim_sleep();
        wr(5'h01, 8'hFF);
        wr(5'h02, 8'hFF);
        chk({9'h0, trim_value_out}, 18'h1FF);
        chk({17'h0, manchester_enable_out}, 18'h0);
        rd_chk(5'h02, 8'h0F);
        wr(5'h01, 8'hB0);
        wr(5'h03, 8'hA5);
        chk({15'h0, modulation_select_out, limit_multiplier_out}, 18'h6);
        chk(sleep_period_out, 18'h2400);
        wr(5'h03, 8'h7E);
        chk(sleep_period_out, 18'h3E000);
        chk({15'h0, modulation_select_out, limit_multiplier_out}, 18'h1);
    endtask
    task automatic t_button();
        wr(5'h02, 8'h08); // aux supply is low here
        chk({16'h0, supply_output_enable_out, clk_out_enable_out}, 18'h0);
        wr(ADDR_STATUS, 8'hFF);
        cyc_wait(1);
        push_button_n_in = 5'h1E;
        cyc_wait(6);
        chk({15'h0, irq_out, supply_output_enable_out, clk_out_enable_out}, 18'h7);
        rd_chk(ADDR_STATUS, 8'h01);
        cyc_wait(1);
        push_button_n_in = 5'h1F;
        cyc_wait(4);
        rd_chk(ADDR_STATUS, 8'h00);
    endtask
    task automatic t_buffer();
        wr(5'h00, 8'h00);
        for (int i = 0; i < 5; i++) wr(ADDR_BUFFER, 8'(8'hA0 + i));
        chk({13'h0, buffer_count_out}, 18'h5);
        wr(5'h00, 8'h02);
        for (int i = 0; i < 5; i++) begin
            pulse_chk(tx_byte_req_in, i == 0 || i == 4);
            chk({10'h0, tx_byte_out}, 18'(8'hA0 + i));
        end
        wr(5'h00, 8'h06);
        for (int i = 0; i < 4; i++) begin
            rx_byte_in = 8'(8'h50 + i);
            pulse_chk(rx_byte_valid_in, i == 3);
        end
        rd_chk(ADDR_BUFFER, 8'h50);
        pulse_chk(rx_error_in, 1'b1);
        pulse_chk(bitcheck_ok_in, 1'b1);
        wr(5'h01, 8'hB1);
        pulse_chk(bitcheck_ok_in, 1'b0);
    endtask

    initial begin
        nrst_in = 1'b0;
        power_on_input_in = 1'b1;
        push_button_n_in = 5'h1F;
        {auxiliary_supply_input_in, low_batt_in, rx_byte_valid_in, rx_byte_in, rx_error_in} = '0;
        {bitcheck_ok_in, tx_byte_req_in, rx_stream_in} = '0;
        cyc_wait(5);
        nrst_in = 1'b1;
        cyc_wait(4);
        power_on_input_in = 1'b0;
        cyc_wait(4);
        t_reset_state();
        t_fields();
        t_trim_sleep();
        t_button();
        t_buffer();
        finish_test();
    end
endmodule // tcrb_reg_bank_test
